// ### sideband_pkg.sv
package sideband_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_CYCLES_DEF = CLK_HZ / 1000 * BLINK_HALF_MS;

  localparam logic [5:0] ADDR_STRAP = 6'h00;
  localparam logic [5:0] ADDR_MGMT_HI = 6'h04;
  localparam logic [5:0] ADDR_LANE_LEAD = 6'h08;
  localparam logic [5:0] ADDR_IRQ_STAT = 6'h0C;
  localparam logic [5:0] ADDR_IRQ_EN = 6'h10;
  localparam logic [5:0] ADDR_GPIO_OE = 6'h14;
  localparam logic [5:0] ADDR_GPIO_OUT = 6'h18;
  localparam logic [5:0] ADDR_GPIO_IN = 6'h1C;
  localparam logic [5:0] ADDR_LINK = 6'h20;

  // Strap bundle layout
  localparam int S_UPS = 0;
  localparam int S_CFG = 4;
  localparam int S_NT_EN_N = 8;
  localparam int S_BRIDGE_N = 9;
  localparam int S_NT_PORT = 10;
  localparam int S_TIMER_N = 14;
  localparam int S_ADDR = 15;
  localparam int S_PROTO = 18;
  localparam int STRAP_W = 19;

  localparam int FATAL_BIT = 8;
  localparam int LINK_GEN2_BIT = 16;

  localparam logic [3:0] MGMT_HI_RST = 4'h0;
  localparam logic [15:0] LANE_LEAD_RST = 16'hFFFF;
  localparam logic [1:0] CAPTURE_WAIT = 2'h2;
endpackage : sideband_pkg

// ### switch_sideband.sv
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
module switch_sideband import sideband_pkg::*; #(
  parameter int BLINK_CYCLES = BLINK_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] upstream_port_strap,
  input wire logic [3:0] port_lane_config_strap,
  input wire logic nontransparent_enable_strap_n,
  input wire logic nt_bridge_mode_strap_n,
  input wire logic [3:0] nt_port_strap,
  input wire logic cfg_timer_strap_n,
  input wire logic [2:0] mgmt_addr_strap,
  input wire logic mgmt_protocol_strap,
  output logic [3:0] upstream_port_sel,
  output logic [3:0] lane_config_sel,
  output logic nt_enable,
  output logic nt_bridge_mode,
  output logic [3:0] nt_port_sel,
  output logic [6:0] mgmt_slave_addr,
  output logic mgmt_i2c_mode,
  input wire logic [15:0] lane_link_up,
  input wire logic [15:0] lane_link_gen2,
  output logic [15:0] lane_status_led,
  input wire logic ltssm_config_fail,
  input wire logic ltssm_detect_exit,
  output logic adv_gen2,
  output logic adv_autonomous,
  input wire logic expander_irq_n,
  output logic expander_scan_req,
  input wire logic [31:0] gpio_in,
  output logic [31:0] gpio_out,
  output logic [31:0] gpio_oe,
  input wire logic fatal_event,
  input wire logic [5:0] irq_events,
  output logic fatal_error_n,
  output logic interrupt_out_n,
  output logic interrupt_oe
);

  if (BLINK_CYCLES < 2) begin : g_chk
    $error("BLINK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [STRAP_W-1:0] strap_s1;
    logic [STRAP_W-1:0] strap_s2;
    logic [STRAP_W-1:0] strap;
    logic [1:0] cap_cnt;
    logic cap_done;
    logic nt_en;
    logic bridge_en;
    logic irq_s1;
    logic irq_s2;
    logic [31:0] gpio_s1;
    logic [31:0] gpio_s2;
    logic [3:0] mgmt_hi;
    logic [15:0] lane_lead;
    logic [5:0] irq_stat;
    logic [5:0] irq_en;
    logic fatal_stat;
    logic fatal_n;
    logic [31:0] gpio_oe;
    logic [31:0] gpio_out;
    logic [31:0] blink_cnt;
    logic blink_phase;
    logic [15:0] led;
    logic fail_pend;
    logic adv_full;
    logic wait_n;
    logic [31:0] rdata;
    logic intr_oe;
    logic scan_req;
  } state_t;

  state_t st_reg;
  state_t st_next;

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_be

  // Lane shows the port whose first lane is the nearest lead at or below it
  function automatic logic [3:0] lead_of(input logic [15:0] lead, input int lane);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (i <= lane && lead[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : lead_of

  ////////////////////////////////////////////////////////////////////////////
  logic bus_req;
  logic bus_ack;
  logic [31:0] strap_word;
  logic [31:0] link_word;

  assign bus_req = avs_read | avs_write;
  assign bus_ack = ~st_reg.wait_n;
  assign strap_word = {{(32-STRAP_W){1'b0}}, st_reg.strap};
  assign link_word = {15'h0000, st_reg.adv_full, st_reg.led};

  always_comb begin
    logic [3:0] ld;
    logic [31:0] ws;
    ld = 4'h0;
    ws = 32'h0000_0000;
    st_next = st_reg;

    // Two-stage synchronisers on all pins from the board
    st_next.strap_s1 = {mgmt_protocol_strap, mgmt_addr_strap, cfg_timer_strap_n, nt_port_strap,
                        nt_bridge_mode_strap_n, nontransparent_enable_strap_n, port_lane_config_strap,
                        upstream_port_strap};
    st_next.strap_s2 = st_reg.strap_s1;
    st_next.irq_s1 = expander_irq_n;
    st_next.irq_s2 = st_reg.irq_s1;
    st_next.gpio_s1 = gpio_in;
    st_next.gpio_s2 = st_reg.gpio_s1;

    // Capture once the synchroniser has filled after release
    if (!st_reg.cap_done) begin
      if (st_reg.cap_cnt == CAPTURE_WAIT) begin
        st_next.strap = st_reg.strap_s2;
        st_next.cap_done = 1'b1;
        st_next.nt_en = ~st_reg.strap_s2[S_NT_EN_N];
        st_next.bridge_en = ~st_reg.strap_s2[S_BRIDGE_N];
      end else begin
        st_next.cap_cnt = st_reg.cap_cnt + 2'h1;
      end
    end

    // Shared phase keeps every blinking lane in step
    if (st_reg.blink_cnt == 32'(BLINK_CYCLES - 1)) begin
      st_next.blink_cnt = 32'h0000_0000;
      st_next.blink_phase = ~st_reg.blink_phase;
    end else begin
      st_next.blink_cnt = st_reg.blink_cnt + 32'h0000_0001;
    end

    for (int l = 0; l < 16; l++) begin
      ld = lead_of(st_reg.lane_lead, l);
      st_next.led[l] = lane_link_up[ld] & (lane_link_gen2[ld] | st_reg.blink_phase);
    end

    // Training fallback; a failure in the same cycle as an exit is kept
    if (st_reg.strap[S_TIMER_N]) begin
      st_next.adv_full = 1'b1;
      st_next.fail_pend = 1'b0;
    end else begin
      if (ltssm_detect_exit) begin
        st_next.adv_full = st_reg.fail_pend ? ~st_reg.adv_full : 1'b1;
        st_next.fail_pend = 1'b0;
      end
      if (ltssm_config_fail) begin
        st_next.fail_pend = 1'b1;
      end
    end

    st_next.scan_req = ~st_reg.irq_s2;

    // Bus: one wait cycle, then a single cycle with waitrequest low
    st_next.wait_n = ~(bus_req & st_reg.wait_n);
    if (avs_read & st_reg.wait_n) begin
      if (avs_address == ADDR_STRAP) begin
        st_next.rdata = strap_word;
      end else if (avs_address == ADDR_MGMT_HI) begin
        st_next.rdata = {28'h0000000, st_reg.mgmt_hi};
      end else if (avs_address == ADDR_LANE_LEAD) begin
        st_next.rdata = {16'h0000, st_reg.lane_lead};
      end else if (avs_address == ADDR_IRQ_STAT) begin
        st_next.rdata = {23'h000000, st_reg.fatal_stat, 2'h0, st_reg.irq_stat};
      end else if (avs_address == ADDR_IRQ_EN) begin
        st_next.rdata = {26'h0000000, st_reg.irq_en};
      end else if (avs_address == ADDR_GPIO_OE) begin
        st_next.rdata = st_reg.gpio_oe;
      end else if (avs_address == ADDR_GPIO_OUT) begin
        st_next.rdata = st_reg.gpio_out;
      end else if (avs_address == ADDR_GPIO_IN) begin
        st_next.rdata = st_reg.gpio_s2;
      end else if (avs_address == ADDR_LINK) begin
        st_next.rdata = link_word;
      end else begin
        st_next.rdata = 32'h0000_0000;
      end
    end

    if (avs_write & bus_ack) begin
      if (avs_address == ADDR_MGMT_HI) begin
        ws = merge_be({28'h0000000, st_reg.mgmt_hi}, avs_writedata, avs_byteenable);
        st_next.mgmt_hi = ws[3:0];
      end else if (avs_address == ADDR_LANE_LEAD) begin
        ws = merge_be({16'h0000, st_reg.lane_lead}, avs_writedata, avs_byteenable);
        // Lane 0 always starts a port
        st_next.lane_lead = ws[15:0] | 16'h0001;
      end else if (avs_address == ADDR_IRQ_STAT) begin
        if (avs_byteenable[0]) begin
          st_next.irq_stat = st_reg.irq_stat & ~avs_writedata[5:0];
        end
        if (avs_byteenable[1] & avs_writedata[FATAL_BIT]) begin
          st_next.fatal_stat = 1'b0;
        end
      end else if (avs_address == ADDR_IRQ_EN) begin
        ws = merge_be({26'h0000000, st_reg.irq_en}, avs_writedata, avs_byteenable);
        st_next.irq_en = ws[5:0];
      end else if (avs_address == ADDR_GPIO_OE) begin
        st_next.gpio_oe = merge_be(st_reg.gpio_oe, avs_writedata, avs_byteenable);
      end else if (avs_address == ADDR_GPIO_OUT) begin
        st_next.gpio_out = merge_be(st_reg.gpio_out, avs_writedata, avs_byteenable);
      end
    end

    // New events win over a clear in the same cycle
    st_next.irq_stat = st_next.irq_stat | irq_events;
    if (fatal_event) begin
      st_next.fatal_stat = 1'b1;
    end
    st_next.fatal_n = ~st_next.fatal_stat;
    st_next.intr_oe = |(st_next.irq_stat & st_next.irq_en);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.lane_lead <= LANE_LEAD_RST;
      st_reg.mgmt_hi <= MGMT_HI_RST;
      st_reg.wait_n <= 1'b1;
      st_reg.adv_full <= 1'b1;
      st_reg.fatal_n <= 1'b1;
      st_reg.irq_s1 <= 1'b1;
      st_reg.irq_s2 <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = st_reg.wait_n;
  assign upstream_port_sel = st_reg.strap[S_UPS +: 4];
  assign lane_config_sel = st_reg.strap[S_CFG +: 4];
  assign nt_enable = st_reg.nt_en;
  assign nt_bridge_mode = st_reg.bridge_en;
  assign nt_port_sel = st_reg.strap[S_NT_PORT +: 4];
  assign mgmt_slave_addr = {st_reg.mgmt_hi, st_reg.strap[S_ADDR +: 3]};
  assign mgmt_i2c_mode = st_reg.strap[S_PROTO];
  assign lane_status_led = st_reg.led;
  assign adv_gen2 = st_reg.adv_full;
  assign adv_autonomous = st_reg.adv_full;
  assign expander_scan_req = st_reg.scan_req;
  assign gpio_out = st_reg.gpio_out;
  assign gpio_oe = st_reg.gpio_oe;
  assign fatal_error_n = st_reg.fatal_n;
  // Open drain: only ever pulls low
  assign interrupt_out_n = 1'b0;
  assign interrupt_oe = st_reg.intr_oe;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence seq_req;
    bus_req && avs_waitrequest;
  endsequence
  sequence seq_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_answer: assert property (seq_req |=> seq_ack)
    else $error("bus request not answered in one cycle");
  a_led_down: assert property (!lane_link_up[0] |=> !lane_status_led[0])
    else $error("lane 0 indicator on while link down");
  a_led_gen2: assert property (lane_link_up[0] && lane_link_gen2[0] |=> lane_status_led[0])
    else $error("lane 0 indicator off at 5GT/s");
  a_blink_step: assert property ($changed(st_reg.blink_phase) |-> $past(st_reg.blink_cnt) == 32'(BLINK_CYCLES - 1))
    else $error("blink phase toggled off its period");
  a_lanes_equal: assert property (!st_reg.lane_lead[1] |=> lane_status_led[1] == lane_status_led[0])
    else $error("lanes of one port differ");
  a_strap_gen2: assert property (st_reg.cap_done && st_reg.strap[S_TIMER_N] |=> adv_gen2 && adv_autonomous)
    else $error("gen1 advertised with timer strap high");
  a_fallback_alt: assert property (ltssm_detect_exit && st_reg.fail_pend && !st_reg.strap[S_TIMER_N]
                                   |=> adv_gen2 != $past(adv_gen2))
    else $error("advertisement did not alternate after failure");
  a_fatal_low: assert property (fatal_event |=> !fatal_error_n)
    else $error("fatal output not driven low");
  a_intr_pull: assert property (|(irq_events & st_reg.irq_en) && $stable(st_reg.irq_en) |=> interrupt_oe)
    else $error("interrupt not pulled on enabled event");
  a_strap_hold: assert property (st_reg.cap_done |=> $stable(st_reg.strap))
    else $error("captured straps changed");
  a_wait_idle: assert property (!bus_req && avs_waitrequest
    |=> avs_waitrequest)
    else $error("bus answered with no request");

  // Capture step: outputs must show what the second synchroniser stage held
  sequence seq_capture;
    !st_reg.cap_done && st_reg.cap_cnt == CAPTURE_WAIT;
  endsequence

  a_ups_capture: assert property (seq_capture
    |=> upstream_port_sel == $past(st_reg.strap_s2[S_UPS +: 4]))
    else $error("upstream port choice differs from strap");
  a_cfg_capture: assert property (seq_capture
    |=> lane_config_sel == $past(st_reg.strap_s2[S_CFG +: 4]))
    else $error("port-lane choice differs from strap");
  a_nt_capture: assert property (seq_capture
    |=> nt_enable == !$past(st_reg.strap_s2[S_NT_EN_N]))
    else $error("non-transparent enable differs from strap");
  a_bridge_capture: assert property (seq_capture
    |=> nt_bridge_mode == !$past(st_reg.strap_s2[S_BRIDGE_N]))
    else $error("bridge mode differs from strap");
  a_ntport_capture: assert property (seq_capture
    |=> nt_port_sel == $past(st_reg.strap_s2[S_NT_PORT +: 4]))
    else $error("non-transparent port choice differs from strap");
  a_addr_capture: assert property (seq_capture
    |=> mgmt_slave_addr[2:0] == $past(st_reg.strap_s2[S_ADDR +: 3]))
    else $error("management address low bits differ from strap");
  a_proto_capture: assert property (seq_capture
    |=> mgmt_i2c_mode == $past(st_reg.strap_s2[S_PROTO]))
    else $error("management protocol differs from strap");

  // Expander line seen at one level for three samples in a row
  sequence seq_expander_low;
    !expander_irq_n ##1 !expander_irq_n ##1 !expander_irq_n;
  endsequence
  sequence seq_expander_high;
    expander_irq_n ##1 expander_irq_n ##1 expander_irq_n;
  endsequence

  a_scan_on: assert property (seq_expander_low
    |=> expander_scan_req)
    else $error("expander read not requested while line low");
  a_scan_off: assert property (seq_expander_high
    |=> !expander_scan_req)
    else $error("expander read requested while line high");

  // A failed Configuration followed by the next Detect exit
  sequence seq_fail_exit;
    ltssm_config_fail && !ltssm_detect_exit ##1 ltssm_detect_exit;
  endsequence

  a_adv_fallback: assert property (!st_reg.strap[S_TIMER_N] && !st_reg.fail_pend && adv_gen2
    ##0 seq_fail_exit |=> !adv_gen2 && !adv_autonomous)
    else $error("first failure did not fall back to first generation");
  a_adv_plain: assert property (ltssm_detect_exit && !st_reg.fail_pend
    |=> adv_gen2 && adv_autonomous)
    else $error("second generation not advertised after clean exit");

  a_led_blink: assert property (lane_link_up[0] && !lane_link_gen2[0]
    |=> lane_status_led[0] == $past(st_reg.blink_phase))
    else $error("lane 0 indicator not following the blink phase");
  a_led_own: assert property (st_reg.lane_lead[4] && lane_link_up[4] && lane_link_gen2[4]
    |=> lane_status_led[4])
    else $error("lane 4 indicator off while its link is up");
  a_gpio_drive: assert property (avs_write && !avs_waitrequest && avs_address == ADDR_GPIO_OE
    && avs_byteenable == 4'hF |=> gpio_oe == $past(avs_writedata))
    else $error("pin direction write not applied");
  a_fatal_hold: assert property (!fatal_error_n && !(avs_write && avs_address == ADDR_IRQ_STAT)
    |=> !fatal_error_n)
    else $error("fatal output released without a clear");
  a_intr_clear: assert property (avs_write && !avs_waitrequest && avs_address == ADDR_IRQ_STAT
    && avs_byteenable[0] && avs_writedata[5:0] == 6'h3F && irq_events == 6'h00 |=> !interrupt_oe)
    else $error("interrupt still pulled after full clear");
endmodule : switch_sideband

// ### board_model.sv
`timescale 1ns/1ns
module board_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic alt,
  input wire logic timer_n,
  input wire logic irq_raise,
  input wire logic expander_scan_req,
  input wire logic [31:0] gpio_out,
  input wire logic [31:0] gpio_oe,
  input wire logic [31:0] board_gpio,
  output logic [18:0] straps,
  output logic expander_irq_n,
  output logic [31:0] gpio_in
);
  logic [18:0] base;
  logic [1:0] reads;
  ////////////////////////////////////////////////////////////
  // Alt flips every strap but the timer strap, so a held capture can be told apart
  assign base = alt ? 19'h0D5CA : 19'h72A35;
  assign straps = {base[18:15], timer_n, base[13:0]};
  // Undriven pins fall back to the board level
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & board_gpio);
  ////////////////////////////////////////////////////////////
  // Pull-up holds the line high until an expander has a change
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      expander_irq_n <= 1'b1;
      reads <= 2'h0;
    end else if (irq_raise) begin
      expander_irq_n <= 1'b0;
      reads <= 2'h0;
    end else if (!expander_irq_n && expander_scan_req) begin
      reads <= reads + 2'h1;
      if (reads == 2'h1) expander_irq_n <= 1'b1;
    end
  end
endmodule : board_model

// ### tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb import sideband_pkg::*; ();
  logic clk_sys = 1'b0;
  logic sys_rst, avs_read, avs_write, avs_waitrequest, ltssm_config_fail, ltssm_detect_exit, adv_gen2;
  logic adv_autonomous, expander_irq_n, expander_scan_req, fatal_event, fatal_error_n, interrupt_out_n;
  logic interrupt_oe, nt_enable, nt_bridge_mode, mgmt_i2c_mode, alt, timer_n, irq_raise;
  logic [5:0] avs_address, irq_events;
  logic [31:0] avs_writedata, avs_readdata, rd, gpio_in, gpio_out, gpio_oe, board_gpio;
  logic [3:0] avs_byteenable, upstream_port_sel, lane_config_sel, nt_port_sel;
  logic [6:0] mgmt_slave_addr;
  logic [15:0] lane_link_up, lane_link_gen2, lane_status_led;
  logic [15:0] smp [32];
  logic [18:0] straps;
  int failures = 0;
  int n_checks = 0;
  typedef struct packed {logic [5:0] en; logic [5:0] ev; logic oe;} row_t;
  row_t rows [7] = '{'{6'h3F, 6'h01, 1'b1}, '{6'h3F, 6'h02, 1'b1}, '{6'h3F, 6'h04, 1'b1},
    '{6'h3F, 6'h08, 1'b1}, '{6'h3F, 6'h10, 1'b1}, '{6'h3F, 6'h20, 1'b1}, '{6'h1F, 6'h20, 1'b0}};
  ////////////////////////////////////////////////////////////
  switch_sideband #(.BLINK_CYCLES(8)) u_dut (.clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .upstream_port_strap(straps[S_UPS+:4]), .port_lane_config_strap(straps[S_CFG+:4]),
    .nontransparent_enable_strap_n(straps[S_NT_EN_N]), .nt_bridge_mode_strap_n(straps[S_BRIDGE_N]),
    .nt_port_strap(straps[S_NT_PORT+:4]), .cfg_timer_strap_n(straps[S_TIMER_N]),
    .mgmt_addr_strap(straps[S_ADDR+:3]), .mgmt_protocol_strap(straps[S_PROTO]), .upstream_port_sel,
    .lane_config_sel, .nt_enable, .nt_bridge_mode, .nt_port_sel, .mgmt_slave_addr, .mgmt_i2c_mode,
    .lane_link_up, .lane_link_gen2, .lane_status_led, .ltssm_config_fail, .ltssm_detect_exit, .adv_gen2,
    .adv_autonomous, .expander_irq_n, .expander_scan_req, .gpio_in, .gpio_out, .gpio_oe, .fatal_event,
    .irq_events, .fatal_error_n, .interrupt_out_n, .interrupt_oe);
  board_model u_board (.clk_sys, .sys_rst, .alt, .timer_n, .irq_raise, .expander_scan_req, .gpio_out,
    .gpio_oe, .board_gpio, .straps, .expander_irq_n, .gpio_in);
  always #10 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // Request held until waitrequest is seen low; one idle edge after
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic do_reset(input logic a, input logic t);
    alt <= a;
    timer_n <= t;
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    `CHK("rst", 36'h800000000, {fatal_error_n, gpio_oe, interrupt_oe, lane_status_led[0], expander_scan_req})
    sys_rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
  endtask : do_reset
  task automatic chk_straps(input logic [18:0] s);
    `CHK("ups", s[S_UPS+:4], upstream_port_sel)
    `CHK("cfg", s[S_CFG+:4], lane_config_sel)
    `CHK("nten", ~s[S_NT_EN_N], nt_enable)
    `CHK("bridge", ~s[S_BRIDGE_N], nt_bridge_mode)
    `CHK("ntport", s[S_NT_PORT+:4], nt_port_sel)
    `CHK("addr", s[S_ADDR+:3], mgmt_slave_addr[2:0])
    `CHK("proto", s[S_PROTO], mgmt_i2c_mode)
  endtask : chk_straps
  task automatic train(input logic f, input logic e);
    ltssm_config_fail <= f;
    @(posedge clk_sys);
    ltssm_config_fail <= 1'b0;
    ltssm_detect_exit <= 1'b1;
    @(posedge clk_sys);
    ltssm_detect_exit <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("adv", {e, e}, {adv_gen2, adv_autonomous})
  endtask : train
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    end_sim();
  end
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= {2'b00, 6'h00, 32'h0, 4'hF};
    {irq_raise, fatal_event, irq_events, ltssm_config_fail, ltssm_detect_exit} <= '0;
    {lane_link_up, lane_link_gen2, board_gpio} <= {32'h0, 32'h3C3C3C3C};
    do_reset(1'b0, 1'b0);
    chk_straps(19'h72A35);
    alt <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk_straps(19'h72A35);
    bus(1'b0, ADDR_STRAP, 32'h0);
    `CHK("strap_reg", 32'h00072A35, rd)
    bus(1'b1, ADDR_STRAP, 32'h0);
    bus(1'b0, ADDR_STRAP, 32'h0);
    `CHK("strap_ro", 32'h00072A35, rd)
    bus(1'b0, 6'h3C, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b1, ADDR_MGMT_HI, 32'h9);
    `CHK("mgmt_hi", 7'h4E, mgmt_slave_addr)
    `CHK("int_pin", 1'b0, interrupt_out_n)
    $display("straps done");
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, ADDR_IRQ_EN, {26'h0, rows[i].en});
      irq_events <= rows[i].ev;
      @(posedge clk_sys);
      irq_events <= 6'h00;
      repeat (2) @(posedge clk_sys);
      `CHK("int_oe", rows[i].oe, interrupt_oe)
      bus(1'b0, ADDR_IRQ_STAT, 32'h0);
      `CHK("irq_stat", {26'h0, rows[i].ev}, rd)
      bus(1'b1, ADDR_IRQ_STAT, 32'h3F);
      `CHK("int_clr", 1'b0, interrupt_oe)
    end
    $display("events done");
    lane_link_up <= 16'hFFFF;
    lane_link_gen2 <= 16'hFFFF;
    repeat (2) @(posedge clk_sys);
    `CHK("led_g2", 16'hFFFF, lane_status_led)
    bus(1'b0, ADDR_LINK, 32'h0);
    `CHK("link_reg", 32'h0001FFFF, rd)
    lane_link_up <= 16'h0000;
    repeat (2) @(posedge clk_sys);
    `CHK("led_dn", 16'h0000, lane_status_led)
    bus(1'b1, ADDR_LANE_LEAD, 32'hFFF0);
    bus(1'b0, ADDR_LANE_LEAD, 32'h0);
    `CHK("lead_reg", 32'h0000FFF1, rd)
    lane_link_up <= 16'h0011;
    lane_link_gen2 <= 16'h0010;
    repeat (2) @(posedge clk_sys);
    for (int k = 0; k < 32; k++) begin
      smp[k] = lane_status_led;
      @(posedge clk_sys);
    end
    for (int k = 0; k < 24; k++) begin
      `CHK("blink", ~smp[k][0], smp[k+8][0])
      `CHK("group", {4{smp[k][0]}}, smp[k][3:0])
      `CHK("lanes", 2'b01, smp[k][5:4])
    end
    $display("leds done");
    train(1'b1, 1'b0);
    train(1'b1, 1'b1);
    train(1'b1, 1'b0);
    train(1'b0, 1'b1);
    $display("training done");
    fatal_event <= 1'b1;
    @(posedge clk_sys);
    fatal_event <= 1'b0;
    repeat (8) @(posedge clk_sys);
    `CHK("fatal", 1'b0, fatal_error_n)
    bus(1'b1, ADDR_IRQ_STAT, 32'h100);
    `CHK("fatal_clr", 1'b1, fatal_error_n)
    irq_raise <= 1'b1;
    @(posedge clk_sys);
    irq_raise <= 1'b0;
    repeat (5) @(posedge clk_sys);
    `CHK("scan", 1'b1, expander_scan_req)
    repeat (8) @(posedge clk_sys);
    `CHK("scan_end", 2'b10, {expander_irq_n, expander_scan_req})
    bus(1'b1, ADDR_GPIO_OE, 32'h0000FFFF);
    bus(1'b1, ADDR_GPIO_OUT, 32'hA5A5A5A5);
    repeat (4) @(posedge clk_sys);
    bus(1'b0, ADDR_GPIO_IN, 32'h0);
    `CHK("gpio_in", 32'h3C3CA5A5, rd)
    `CHK("gpio_oe", 32'h0000FFFF, gpio_oe)
    fatal_event <= 1'b1;
    @(posedge clk_sys);
    fatal_event <= 1'b0;
    $display("pins done");
    do_reset(1'b1, 1'b1);
    chk_straps({4'h1, 1'b1, 14'h15CA});
    train(1'b1, 1'b1);
    $display("second reset done");
    end_sim();
  end
endmodule : tb
